// ===== core/sac_ctrl.sv
// Operation
// - channel-select upper two bits read zero
// - mux enable gates all analog pin routing
// - port field selects ports zero to three
// - pin field selects pin zero to seven
// - only the chosen pin goes analog
// - period field divides by 1,2,4,8,16
// - gain field selects 1,2,4,8,16,0.5
// - enable low holds converter in shutdown
// - track mode 0 tracks except converting
// - track mode 1 tracks 3 sar clocks
// - start mode: software 00, timer 11
// - busy write 1 starts only mode 00
// - busy high during conversion; fall signals
// - complete flag set by hardware or by a software write of 1
// - window flag set on an out-of-window result or by a software write of 1
// - justify bit is plain storage
// - data register holds latest unsigned result
// - window detector compares every result
// - upper limit resets to all ones
// - lower limit resets to all zeros
// - conversion lasts 16 sar clocks
`include "sac_defs.svh"
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       timer2_ovf_i,
  input  wire logic [7:0] sar_data_i,
  output logic            shutdown_o,
  output logic            track_o,
  output logic            sar_step_o,
  output logic      [2:0] gain_select_field_o,
  output sac_route_t      route_o,
  output logic            busy_fall_o
);
  // ============================================================
  // registers
  sac_chsel_t  chsel;
  logic [7:0]  cfg;
  logic [7:0]  result;
  logic [7:0]  upper;
  logic [7:0]  lower;
  logic        en_bit;
  logic        tm_bit;
  logic        done_flag;
  logic        win_flag;
  logic [1:0]  stm;
  logic        just_bit;
  sac_state_t  state;
  logic [3:0]  div_cnt;
  logic [4:0]  step_cnt;
  logic        busy;
  logic        busy_q;
  logic        sar_tick;
  logic [3:0]  div_max;
  logic        wr_chsel;
  logic        wr_cfg;
  logic        wr_result;
  logic        wr_upper;
  logic        wr_lower;
  logic        wr_ctrl;
  logic        sw_start;
  logic        trig;
  logic        finish;
  logic        win_hit;

  // ============================================================
  // address decode
  always_comb
  begin
    wr_chsel  = 1'b0;
    wr_cfg    = 1'b0;
    wr_result = 1'b0;
    wr_upper  = 1'b0;
    wr_lower  = 1'b0;
    wr_ctrl   = 1'b0;
    if (sfr_addr_i == `SAC_ADDR_CHSEL)
      wr_chsel = sfr_wr_i;
    else if (sfr_addr_i == `SAC_ADDR_CFG)
      wr_cfg = sfr_wr_i;
    else if (sfr_addr_i == `SAC_ADDR_RESULT)
      wr_result = sfr_wr_i;
    else if (sfr_addr_i == `SAC_ADDR_UPPER)
      wr_upper = sfr_wr_i;
    else if (sfr_addr_i == `SAC_ADDR_LOWER)
      wr_lower = sfr_wr_i;
    else if (sfr_addr_i == `SAC_ADDR_CTRL)
      wr_ctrl = sfr_wr_i;
  end

  always_comb
  begin
    if (sfr_addr_i == `SAC_ADDR_CHSEL)
      sfr_rdata_o = {2'b00, chsel};
    else if (sfr_addr_i == `SAC_ADDR_CFG)
      sfr_rdata_o = cfg;
    else if (sfr_addr_i == `SAC_ADDR_RESULT)
      sfr_rdata_o = result;
    else if (sfr_addr_i == `SAC_ADDR_UPPER)
      sfr_rdata_o = upper;
    else if (sfr_addr_i == `SAC_ADDR_LOWER)
      sfr_rdata_o = lower;
    else if (sfr_addr_i == `SAC_ADDR_CTRL)
      sfr_rdata_o = {en_bit, tm_bit, done_flag, busy, stm, win_flag, just_bit};
    else
      sfr_rdata_o = 8'h00;
  end

  // ============================================================
  // configuration registers
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      chsel <= sac_chsel_t'(`SAC_RST_CHSEL);
    else if (wr_chsel)
      chsel <= sac_chsel_t'(sfr_wdata_i[5:0]);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cfg <= `SAC_RST_CFG;
    else if (wr_cfg)
      cfg <= sfr_wdata_i & `SAC_CFG_MASK;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      upper <= `SAC_RST_UPPER;
      lower <= `SAC_RST_LOWER;
    end
    else
    begin
      if (wr_upper)
        upper <= sfr_wdata_i;
      if (wr_lower)
        lower <= sfr_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      en_bit   <= 1'b0;
      tm_bit   <= 1'b0;
      stm      <= 2'b00;
      just_bit <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      en_bit   <= sfr_wdata_i[`SAC_BIT_EN];
      tm_bit   <= sfr_wdata_i[`SAC_BIT_TM];
      stm      <= sfr_wdata_i[3:2];
      just_bit <= sfr_wdata_i[`SAC_BIT_JUST];
    end
  end

  // ============================================================
  // analog routing and gain
  assign gain_select_field_o = cfg[2:0];

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      assign route_o.pin_en[gi] = chsel.mux_en && (chsel.pin == 3'(gi));
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_port
      assign route_o.port_en[gi] = chsel.mux_en && (chsel.port == 2'(gi));
    end
  endgenerate

  // ============================================================
  // sar clock divider
  always_comb
  begin
    if (cfg[7])
      div_max = 4'd15;
    else
      div_max = 4'((4'd1 << cfg[6:5]) - 4'd1);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt <= 4'd0;
    else if (state == SAC_IDLE || div_cnt >= div_max)
      div_cnt <= 4'd0;
    else
      div_cnt <= div_cnt + 4'd1;
  end

  // one tick per sar clock; the first tick ends the first period after start
  assign sar_tick   = (state != SAC_IDLE) && (div_cnt >= div_max);
  assign sar_step_o = sar_tick;

  // ============================================================
  // conversion sequencer
  // reserved start modes never trigger
  assign sw_start = wr_ctrl && sfr_wdata_i[`SAC_BIT_BUSY] && (stm == `SAC_STM_SW);
  assign trig     = en_bit && (sw_start || (timer2_ovf_i && stm == `SAC_STM_TMR));
  assign finish   = (state == SAC_CONV) && sar_tick && (step_cnt == `SAC_CONV_SAR - 5'd1);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state    <= SAC_IDLE;
      step_cnt <= 5'd0;
    end
    else if (!en_bit)
    begin
      state    <= SAC_IDLE;
      step_cnt <= 5'd0;
    end
    else
    begin
      case (state)
        SAC_IDLE:
          if (trig)
          begin
            state    <= tm_bit ? SAC_TRACK : SAC_CONV;
            step_cnt <= 5'd0;
          end
        SAC_TRACK:
          if (sar_tick)
          begin
            if (step_cnt == 5'(`SAC_TRACK_SAR) - 5'd1)
            begin
              state    <= SAC_CONV;
              step_cnt <= 5'd0;
            end
            else
              step_cnt <= step_cnt + 5'd1;
          end
        SAC_CONV:
          if (sar_tick)
          begin
            if (finish)
            begin
              state    <= SAC_IDLE;
              step_cnt <= 5'd0;
            end
            else
              step_cnt <= step_cnt + 5'd1;
          end
        default:
          state <= SAC_IDLE;
      endcase
    end
  end

  assign busy       = (state != SAC_IDLE);
  assign shutdown_o = !en_bit;
  assign track_o    = en_bit && (tm_bit ? (state == SAC_TRACK) : (state == SAC_IDLE));

  // ============================================================
  // result, flags
  assign win_hit = (sar_data_i > upper) || (sar_data_i < lower);

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      result <= `SAC_RST_RESULT;
    else if (finish)
      result <= sar_data_i;
    else if (wr_result)
      result <= sfr_wdata_i;
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      done_flag <= 1'b0;
      win_flag  <= 1'b0;
    end
    else
    begin
      if (finish)
        done_flag <= 1'b1;
      else if (wr_ctrl)
        done_flag <= sfr_wdata_i[`SAC_BIT_DONE];
      if (finish && win_hit)
        win_flag <= 1'b1;
      else if (wr_ctrl)
        win_flag <= sfr_wdata_i[`SAC_BIT_WIN];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      busy_q <= 1'b0;
    else
      busy_q <= busy;
  end

  assign busy_fall_o = busy_q && !busy;

  // ============================================================
  // checks
  a_chsel_upper_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    sfr_addr_i == `SAC_ADDR_CHSEL |-> sfr_rdata_o[7:6] == 2'b00)
    else $error("channel select upper bits not zero");
  a_route_off_gate: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !chsel.mux_en |-> route_o.pin_en == 8'h00 && route_o.port_en == 4'h0)
    else $error("pin routed while mux disabled");
  a_route_one_pin: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    chsel.mux_en |-> $onehot(route_o.pin_en) && $onehot(route_o.port_en))
    else $error("routing not a single pin");
  a_busy_sw_start: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    state == SAC_IDLE && en_bit && sw_start |=> busy)
    else $error("software start ignored");
  a_busy_reserved: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    state == SAC_IDLE && (stm == 2'b01 || stm == 2'b10) |=> !busy)
    else $error("reserved mode started conversion");
  a_done_on_fall: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $fell(busy) && en_bit |-> done_flag && result == $past(sar_data_i))
    else $error("completion flag or result missing");
  a_done_sticky: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    done_flag && !$past(wr_ctrl) |-> $past(done_flag) || $past(finish))
    else $error("completion flag changed without cause");
  a_track_len: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(state == SAC_TRACK) && cfg[7:5] == 3'b000 && en_bit |->
      (state == SAC_TRACK) [*3] ##1 (state == SAC_CONV || !en_bit))
    else $error("track phase not three sar clocks");
  a_conv_len: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $rose(state == SAC_CONV) && cfg[7:5] == 3'b000 && en_bit && !wr_cfg |->
      ##15 (state == SAC_CONV || !en_bit))
    else $error("conversion shorter than sixteen sar clocks");
endmodule : sac_ctrl
`default_nettype wire

// ===== core/sac_defs.svh
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
// ============================================================
// register addresses
`define SAC_ADDR_CHSEL   8'hbb
`define SAC_ADDR_CFG     8'hbc
`define SAC_ADDR_RESULT  8'hbf
`define SAC_ADDR_UPPER   8'hc5
`define SAC_ADDR_LOWER   8'hc7
`define SAC_ADDR_CTRL    8'he8
// ============================================================
// reset values
`define SAC_RST_CHSEL    8'h00
`define SAC_RST_CFG      8'h60
`define SAC_RST_RESULT   8'h00
`define SAC_RST_UPPER    8'hff
`define SAC_RST_LOWER    8'h00
`define SAC_RST_CTRL     8'h00
// ============================================================
// field masks and positions
`define SAC_CHSEL_MASK   8'h3f
`define SAC_CFG_MASK     8'he7
`define SAC_BIT_EN       7
`define SAC_BIT_TM       6
`define SAC_BIT_DONE     5
`define SAC_BIT_BUSY     4
`define SAC_BIT_WIN      1
`define SAC_BIT_JUST     0
`define SAC_STM_SW       2'b00
`define SAC_STM_TMR      2'b11
// ============================================================
// timing in sar clocks
`define SAC_TRACK_SAR    3'd3
`define SAC_CONV_SAR     5'd16
`endif

// ===== core/sac_pkg.sv
`default_nettype none
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_TRACK,
    SAC_CONV
  } sac_state_t;

  typedef struct packed {
    logic       mux_en;
    logic [1:0] port;
    logic [2:0] pin;
  } sac_chsel_t;

  typedef struct packed {
    logic [3:0] port_en;
    logic [7:0] pin_en;
  } sac_route_t;
endpackage : sac_pkg
`default_nettype wire

// ===== verification/sac_cpu_model.sv
`include "sac_defs.svh"
`default_nettype none
module sac_cpu_model
(
  input  wire logic       core_clk_i,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  input  wire logic [7:0] sfr_rdata_i,
  output logic            timer2_ovf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = 8'h00;
    timer2_ovf_o = 1'b0;
  end
  // ==========================================
  // bus cycles, launched off the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(negedge core_clk_i);
    sfr_wr_o = 1'b0;
    // stale data must not look valid
    sfr_wdata_o = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    sfr_addr_o = a;
    #1;
    d = sfr_rdata_i;
  endtask : rd
  task automatic tick();
    @(negedge core_clk_i);
    timer2_ovf_o = 1'b1;
    @(negedge core_clk_i);
    timer2_ovf_o = 1'b0;
  endtask : tick
  // polls the complete flag, never busy
  task automatic wait_done(output logic ok);
    logic [7:0] v;
    ok = 1'b0;
    repeat (400)
    begin
      if (!ok)
      begin
        rd(`SAC_ADDR_CTRL, v);
        ok = (v[`SAC_BIT_DONE] === 1'b1);
      end
    end
  endtask : wait_done
endmodule : sac_cpu_model
`default_nettype wire

// ===== verification/sac_ctrl_tb.sv
`include "sac_defs.svh"
`default_nettype none
module sac_ctrl_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       arst_n;
  logic [7:0] addr;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       tmr;
  logic [7:0] sar_data;
  logic       shutdown;
  logic       track;
  logic       step;
  logic [2:0] gain;
  sac_route_t route;
  logic       bfall;
  int         n_fail;
  int         checked;
  int         steps;
  int         span;
  logic       exp_tm;
  int         cycles;
  int         exp_q[$];
  integer     seed;
  sac_ctrl dut_u (.core_clk_i(clk), .arst_n_i(arst_n), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .timer2_ovf_i(tmr), .sar_data_i(sar_data), .shutdown_o(shutdown),
    .track_o(track), .sar_step_o(step), .gain_select_field_o(gain),
    .route_o(route), .busy_fall_o(bfall));
  sac_cpu_model cpu_u (.core_clk_i(clk), .sfr_addr_o(addr), .sfr_wr_o(wr),
    .sfr_wdata_o(wdata), .sfr_rdata_i(rdata), .timer2_ovf_o(tmr));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // checks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu_u.rd(a, v);
    chk({4'h0, v}, {4'h0, e});
  endtask : rchk
  task automatic tally_and_finish();
    $display("counts: %0d checked, %0d failed", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // monitor: sar clocks and system clocks per conversion, sampled mid-cycle
  always @(negedge clk)
  begin
    if (bfall === 1'b1)
    begin
      chk(12'(steps), 12'(exp_q.pop_front()));
      chk(12'(span), 12'(exp_q.pop_front()));
      steps = 0;
      span = 0;
    end
    else
    begin
      if (step === 1'b1)
      begin
        chk({11'h0, track}, {11'h0, exp_tm && steps < 3});
        steps++;
      end
      if (steps > 0)
        span++;
    end
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ==========================================
  // one conversion, software or timer started
  task automatic convert(input logic [2:0] dv, input logic tm, input logic tr,
                         input logic [7:0] d, input logic [7:0] up,
                         input logic [7:0] lo);
    logic       ok;
    logic [7:0] c;
    int         p;
    sar_data = d;
    c = {1'b1, tm, 2'b00, tr, tr, 2'b00};
    p = dv[2] ? 16 : (1 << dv[1:0]);
    exp_tm = tm;
    cpu_u.wr(`SAC_ADDR_UPPER, up);
    cpu_u.wr(`SAC_ADDR_LOWER, lo);
    // bench clock outruns the sar rate limit; only the divide ratio is checked
    cpu_u.wr(`SAC_ADDR_CFG, {dv, 5'h00});
    cpu_u.wr(`SAC_ADDR_CTRL, c);
    exp_q.push_back(tm ? 19 : 16);
    exp_q.push_back((tm ? 18 : 15) * p + 1);
    cpu_u.wr(`SAC_ADDR_CTRL, c | 8'h10);
    if (tr)
    begin
      rchk(`SAC_ADDR_CTRL, c);
      cpu_u.tick();
    end
    cpu_u.wait_done(ok);
    chk({11'h0, ok}, 12'h001);
    rchk(`SAC_ADDR_RESULT, d);
    rchk(`SAC_ADDR_CTRL, c | 8'h20 | {6'h0, d > up || d < lo, 1'b0});
  endtask : convert
  initial
  begin
    logic [7:0] v;
    seed = 32'h0428_2185;
    arst_n = 1'b0;
    sar_data = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    rchk(`SAC_ADDR_CHSEL, 8'h00);
    rchk(`SAC_ADDR_CFG, 8'h60);
    rchk(`SAC_ADDR_RESULT, 8'h00);
    rchk(`SAC_ADDR_UPPER, 8'hff);
    rchk(`SAC_ADDR_LOWER, 8'h00);
    rchk(`SAC_ADDR_CTRL, 8'h00);
    rchk(8'haa, 8'h00);
    chk({10'h0, shutdown, track}, 12'h002);
    $display("test reset done");
    for (int i = 0; i < 32; i++)
    begin
      v = 8'($random(seed));
      // pin input mode lives in the port logic outside this block
      cpu_u.wr(`SAC_ADDR_CHSEL, v);
      rchk(`SAC_ADDR_CHSEL, v & 8'h3f);
      chk(route, v[5] ? {4'h1 << v[4:3], 8'h01 << v[2:0]} : 12'h000);
    end
    for (int g = 0; g < 8; g++)
    begin
      cpu_u.wr(`SAC_ADDR_CFG, {5'h1f, 3'(g)});
      rchk(`SAC_ADDR_CFG, {5'h1c, 3'(g)});
      chk({9'h0, gain}, 12'(g));
    end
    cpu_u.wr(`SAC_ADDR_CTRL, 8'h81);
    chk({10'h0, shutdown, track}, 12'h001);
    rchk(`SAC_ADDR_CTRL, 8'h81);
    $display("test fields done");
    convert(3'd0, 1'b1, 1'b0, 8'h80, 8'h80, 8'h80);
    convert(3'd0, 1'b0, 1'b0, 8'h7f, 8'h80, 8'h80);
    for (int i = 0; i < 8; i++)
      convert(3'(i), i[0], i[1], 8'($random(seed)), 8'($random(seed)),
              8'($random(seed)));
    $display("test conversions done");
    cpu_u.wr(`SAC_ADDR_CTRL, 8'h84);
    cpu_u.wr(`SAC_ADDR_CTRL, 8'h94);
    cpu_u.tick();
    rchk(`SAC_ADDR_CTRL, 8'h84);
    $display("test reserved done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : sac_ctrl_tb
`default_nettype wire
